// ---- dpt_pkg.sv ----
// Constants and types shared by the digital channel block
package dpt_pkg;

    localparam int          CHAN_COUNT      = 8;
    localparam int          STRENGTH_FIRST  = 1;
    localparam int          STRENGTH_LAST   = 5;
    localparam int          STRENGTH_COUNT  = 5;
    localparam int          TRIG_PIN_INDEX  = 7;
    localparam int          TRIG_REPEAT     = 3;

    // Register byte offsets
    localparam logic [7:0]  OFS_CHAN_DIR    = 8'h00;
    localparam logic [7:0]  OFS_CHAN_LEVEL  = 8'h04;
    localparam logic [7:0]  OFS_GLOBAL      = 8'h08;
    localparam logic [7:0]  OFS_CMD_CFG     = 8'h0C;
    localparam logic [7:0]  OFS_TRIG_GAP    = 8'h10;
    localparam logic [7:0]  OFS_NET_PORT    = 8'h14;
    localparam logic [7:0]  OFS_STATUS      = 8'h18;
    localparam logic [7:0]  OFS_CMD_CTRL    = 8'h1C;

    // Field positions
    localparam int          GLB_DIR_BIT     = 0;
    localparam int          GLB_LEVEL_BIT   = 1;
    localparam int          CFG_MODE_LSB    = 0;
    localparam int          CFG_MODE_MSB    = 1;
    localparam int          CFG_LED_BIT     = 8;
    localparam int          CFG_CHAR_LSB    = 16;
    localparam int          CFG_CHAR_MSB    = 23;
    localparam int          STAT_CMD_BIT    = 8;
    localparam int          CTRL_EXIT_BIT   = 0;
    localparam int          NET_PORT_MSB    = 13;

    // Command-mode entry methods
    typedef enum logic [1:0] {
        ENTRY_DISABLED = 2'b00,
        ENTRY_PIN      = 2'b01,
        ENTRY_CHARS    = 2'b10,
        ENTRY_BREAK    = 2'b11
    } dpt_entry_e;

    // Reset values and port number limit
    localparam logic [7:0]  RST_CHAN_DIR    = 8'h00;
    localparam logic [7:0]  RST_CHAN_LEVEL  = 8'h00;
    localparam logic [1:0]  RST_GLOBAL      = 2'h0;
    localparam logic        RST_LED_ENABLE  = 1'b1;
    localparam logic [7:0]  RST_TRIG_CHAR   = 8'h2B;
    localparam logic [13:0] RST_NET_PORT    = 14'h1389;
    localparam logic [13:0] NET_PORT_MAX    = 14'h270F;

    // Timing
    localparam int          CLK_MHZ         = 200;
    localparam int          TRIG_GAP_US     = 1000;
    localparam int          TRIG_GAP_CYCLES = TRIG_GAP_US * CLK_MHZ;

endpackage

// ---- dpt_trigger_detect.sv ----
// Detects three trigger characters arriving within the gap limit
`timescale 1ns/1ps
module dpt_trigger_detect
    import dpt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        enable,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic [7:0]  trigChar,
    input  wire logic [31:0] gapLimit,
    output logic             hit
);

    logic [1:0]  count;
    logic [31:0] gap;
    logic        gapExpired;

    assign gapExpired = (gap >= gapLimit);

    // Gap timer restarts on each received character
    always_ff @(posedge clk) begin
        if (sys_rst || rxValid || count == 2'd0) begin
            gap <= 32'h0000_0000;
        end else if (!gapExpired) begin
            gap <= gap + 32'h0000_0001;
        end
    end

    // Consecutive trigger character counter
    always_ff @(posedge clk) begin
        if (sys_rst || !enable) begin
            count <= 2'd0;
            hit   <= 1'b0;
        end else begin
            hit <= 1'b0;
            if (rxValid) begin
                if (rxData != trigChar) begin
                    count <= 2'd0;
                end else if (count == 2'(TRIG_REPEAT - 1)) begin
                    count <= 2'd0;
                    hit   <= 1'b1;
                end else begin
                    count <= count + 2'd1;
                end
            end else if (gapExpired && count != 2'd0) begin
                count <= 2'd0;
            end
        end
    end

endmodule

// ---- dpt_port_top.sv ----
// Eight-channel digital I/O port with command-mode entry selector
//
// Functional notes
// - Command mode may be entered by none, the channel 7 pin, three trigger characters or a break, characters being the reset choice.
// - With entry disabled the block never goes into command mode.
// - With pin entry the command mode follows the synchronised level on channel 7.
// - With character entry three trigger characters in quick succession enter command mode.
// - There are 8 channels, each with direction and level, both reset to input and low.
// - An input channel is not driven, its stored level is ignored and the pin level is reported.
// - An output channel drives its stored level onto the pin.
// - A write to the global setting loads every channel's direction and level at once.
// - With the strength LED function on, channels 1 to 5 show signal strength and ignore their own settings.
// - The command service port number is held in 0 to 9999, reset 5001.
`timescale 1ns/1ps
module dpt_port_top
    import dpt_pkg::*;
#(
    parameter logic [31:0] TRIG_GAP_LIMIT = 32'(TRIG_GAP_CYCLES)
)
(
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    input  wire logic [CHAN_COUNT-1:0]     chanIn,
    output logic [CHAN_COUNT-1:0]          chanOut,
    output logic [CHAN_COUNT-1:0]          chanOe,
    input  wire logic [STRENGTH_COUNT-1:0] strengthLevel,
    input  wire logic                      rxValid,
    input  wire logic [7:0]                rxData,
    input  wire logic                      rxBreak,
    output logic                           cmdMode,
    output logic [13:0]                    netPort
);

    typedef enum logic [0:0] {
        MODE_DATA    = 1'b0,
        MODE_COMMAND = 1'b1
    } dpt_cmd_state_e;

    // Register map decode
    function automatic logic isMapped(input logic [7:0] addr);
        case (addr)
            OFS_CHAN_DIR,
            OFS_CHAN_LEVEL,
            OFS_GLOBAL,
            OFS_CMD_CFG,
            OFS_TRIG_GAP,
            OFS_NET_PORT,
            OFS_STATUS,
            OFS_CMD_CTRL: isMapped = 1'b1;
            default:      isMapped = 1'b0;
        endcase
    endfunction

    logic [CHAN_COUNT-1:0] chanDir;
    logic [CHAN_COUNT-1:0] chanLevel;
    logic [1:0]            globalSetting;
    dpt_entry_e            entryMode;
    logic                  strengthLedEnable;
    logic [7:0]            trigChar;
    logic [31:0]           trigGap;
    logic [CHAN_COUNT-1:0] syncMeta;
    logic [CHAN_COUNT-1:0] syncIn;
    logic [CHAN_COUNT-1:0] effDir;
    logic [CHAN_COUNT-1:0] effLevel;
    logic [CHAN_COUNT-1:0] reportLevel;
    dpt_cmd_state_e        cmdState;
    dpt_cmd_state_e        next_cmdState;
    logic                  trigHit;
    logic                  exitReq;
    logic                  accessDone;
    logic                  wrStrobe;
    logic                  rdStrobe;
    logic [31:0]           next_prdata;
    logic                  wrDir;
    logic                  wrLevel;
    logic                  wrGlobal;
    logic                  wrCfg;
    logic                  wrGap;
    logic                  wrPort;
    logic                  wrCtrl;

    // APB access phase: answer comes one cycle after penable rises
    assign accessDone = psel && penable && !pready;
    assign wrStrobe   = accessDone && pwrite;
    assign rdStrobe   = accessDone && !pwrite;

    // One write strobe per register except the status register
    assign wrDir    = wrStrobe && (paddr == OFS_CHAN_DIR);
    assign wrLevel  = wrStrobe && (paddr == OFS_CHAN_LEVEL);
    assign wrGlobal = wrStrobe && (paddr == OFS_GLOBAL);
    assign wrCfg    = wrStrobe && (paddr == OFS_CMD_CFG);
    assign wrGap    = wrStrobe && (paddr == OFS_TRIG_GAP);
    assign wrPort   = wrStrobe && (paddr == OFS_NET_PORT);
    assign wrCtrl   = wrStrobe && (paddr == OFS_CMD_CTRL);

    // Two-stage pin synchroniser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncMeta <= '0;
            syncIn   <= '0;
        end else begin
            syncMeta <= chanIn;
            syncIn   <= syncMeta;
        end
    end

    // Per-channel direction register with global override
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanDir <= RST_CHAN_DIR;
        end else if (wrGlobal) begin
            chanDir <= {CHAN_COUNT{pwdata[GLB_DIR_BIT]}};
        end else if (wrDir) begin
            chanDir <= pwdata[CHAN_COUNT-1:0];
        end
    end

    // Per-channel level register with global override
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanLevel <= RST_CHAN_LEVEL;
        end else if (wrGlobal) begin
            chanLevel <= {CHAN_COUNT{pwdata[GLB_LEVEL_BIT]}};
        end else if (wrLevel) begin
            chanLevel <= pwdata[CHAN_COUNT-1:0];
        end
    end

    // Last global setting written, kept for readback
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            globalSetting <= RST_GLOBAL;
        end else if (wrGlobal) begin
            globalSetting <= {pwdata[GLB_LEVEL_BIT], pwdata[GLB_DIR_BIT]};
        end
    end

    // Command-mode entry method
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            entryMode <= ENTRY_CHARS;
        end else if (wrCfg) begin
            entryMode <= dpt_entry_e'(
                pwdata[CFG_MODE_MSB:CFG_MODE_LSB]);
        end
    end

    // Strength LED takeover enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strengthLedEnable <= RST_LED_ENABLE;
        end else if (wrCfg) begin
            strengthLedEnable <= pwdata[CFG_LED_BIT];
        end
    end

    // Software trigger character
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trigChar <= RST_TRIG_CHAR;
        end else if (wrCfg) begin
            trigChar <= pwdata[CFG_CHAR_MSB:CFG_CHAR_LSB];
        end
    end

    // Inter-character gap limit in clock cycles
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trigGap <= TRIG_GAP_LIMIT;
        end else if (wrGap) begin
            trigGap <= pwdata;
        end
    end

    // Service port number; out-of-range writes are dropped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            netPort <= RST_NET_PORT;
        end else if (wrPort && pwdata[31:NET_PORT_MSB+1] == '0
                     && pwdata[NET_PORT_MSB:0] <= NET_PORT_MAX) begin
            netPort <= pwdata[NET_PORT_MSB:0];
        end
    end

    // Software request to leave command mode
    assign exitReq = wrCtrl && pwdata[CTRL_EXIT_BIT];

    // Effective direction and level after strength LED takeover
    always_comb begin
        effDir   = chanDir;
        effLevel = chanLevel;
        for (int i = STRENGTH_FIRST; i <= STRENGTH_LAST; i++) begin
            if (strengthLedEnable) begin
                effDir[i]   = 1'b1;
                effLevel[i] = strengthLevel[i - STRENGTH_FIRST];
            end
        end
    end

    // Output enable: high while the block drives the pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanOe <= '0;
        end else begin
            chanOe <= effDir;
        end
    end

    // Pin level: inputs held low, outputs carry their level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanOut <= '0;
        end else begin
            chanOut <= effLevel & effDir;
        end
    end

    // Reported level: pin for inputs, driven level for outputs
    always_comb begin
        for (int i = 0; i < CHAN_COUNT; i++) begin
            reportLevel[i] = effDir[i] ? effLevel[i] : syncIn[i];
        end
    end

    dpt_trigger_detect u_trigger (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .enable   (entryMode == ENTRY_CHARS),
        .rxValid  (rxValid),
        .rxData   (rxData),
        .trigChar (trigChar),
        .gapLimit (trigGap),
        .hit      (trigHit)
    );

    // Command-mode state selection
    always_comb begin
        next_cmdState = cmdState;
        case (entryMode)
            ENTRY_DISABLED: begin
                next_cmdState = MODE_DATA;
            end
            ENTRY_PIN: begin
                next_cmdState = syncIn[TRIG_PIN_INDEX] ? MODE_COMMAND
                                                       : MODE_DATA;
            end
            ENTRY_CHARS: begin
                if (trigHit) begin
                    next_cmdState = MODE_COMMAND;
                end else if (exitReq) begin
                    next_cmdState = MODE_DATA;
                end
            end
            ENTRY_BREAK: begin
                if (rxBreak) begin
                    next_cmdState = MODE_COMMAND;
                end else if (exitReq) begin
                    next_cmdState = MODE_DATA;
                end
            end
            default: begin
                next_cmdState = MODE_DATA;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmdState <= MODE_DATA;
            cmdMode  <= 1'b0;
        end else begin
            cmdState <= next_cmdState;
            cmdMode  <= (next_cmdState == MODE_COMMAND);
        end
    end

    // Read data multiplexer
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            OFS_CHAN_DIR: begin
                next_prdata[CHAN_COUNT-1:0] = chanDir;
            end
            OFS_CHAN_LEVEL: begin
                next_prdata[CHAN_COUNT-1:0] = chanLevel;
            end
            OFS_GLOBAL: begin
                next_prdata[GLB_DIR_BIT]   = globalSetting[0];
                next_prdata[GLB_LEVEL_BIT] = globalSetting[1];
            end
            OFS_CMD_CFG: begin
                next_prdata[CFG_MODE_MSB:CFG_MODE_LSB] = entryMode;
                next_prdata[CFG_LED_BIT]               = strengthLedEnable;
                next_prdata[CFG_CHAR_MSB:CFG_CHAR_LSB] = trigChar;
            end
            OFS_TRIG_GAP: begin
                next_prdata = trigGap;
            end
            OFS_NET_PORT: begin
                next_prdata[NET_PORT_MSB:0] = netPort;
            end
            OFS_STATUS: begin
                next_prdata[CHAN_COUNT-1:0] = reportLevel;
                next_prdata[STAT_CMD_BIT]   = (cmdState == MODE_COMMAND);
            end
            default: begin
                next_prdata = 32'h0000_0000;
            end
        endcase
    end

    // APB answer: ready and error pulse for one cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= accessDone;
            pslverr <= accessDone && !isMapped(paddr);
        end
    end

    // Read data, zero after writes and unmapped reads
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (rdStrobe) begin
            prdata <= next_prdata;
        end else if (accessDone) begin
            prdata <= 32'h0000_0000;
        end
    end

endmodule

// ---- dpt_port_top_asserts.sv ----
// Port-level assertions for the digital channel block
`timescale 1ns/1ps
module dpt_port_top_asserts
    import dpt_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic                  pready,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    input wire logic [CHAN_COUNT-1:0] chanIn,
    input wire logic [CHAN_COUNT-1:0] chanOut,
    input wire logic [CHAN_COUNT-1:0] chanOe,
    input wire logic                  rxValid,
    input wire logic                  rxBreak,
    input wire logic                  cmdMode,
    input wire logic [13:0]           netPort
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_inOff;
        (chanOut & ~chanOe) == 8'h00;
    endproperty
    a_inOff: assert property (p_inOff)
        else $error("undriven channel shows a high level");
    property p_rise;
        $rose(cmdMode) |-> $past(rxBreak) || $past(rxValid, 2)
            || $past(rxValid, 3) || $past(chanIn[7], 2)
            || $past(chanIn[7], 3) || $past(chanIn[7], 4);
    endproperty
    a_rise: assert property (p_rise)
        else $error("command mode entered without a cause");
    property p_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus access not answered next cycle");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready held longer than one cycle");
    property p_errReady;
        pslverr |-> pready && psel && penable;
    endproperty
    a_errReady: assert property (p_errReady)
        else $error("error flag outside an answer");
    property p_prdZero;
        pready && (pwrite || pslverr) |-> prdata == 32'h0000_0000;
    endproperty
    a_prdZero: assert property (p_prdZero)
        else $error("read data not zero on write or error");
    property p_netMax;
        netPort <= 14'd9999;
    endproperty
    a_netMax: assert property (p_netMax)
        else $error("port number above limit");
    property p_rstVal;
        $fell(sys_rst) |-> chanOe == 8'h00 && !cmdMode
            && netPort == 14'd5001;
    endproperty
    a_rstVal: assert property (p_rstVal)
        else $error("wrong value out of reset");

    c_cmd: cover property ($rose(cmdMode));
    c_err: cover property (pslverr);
    c_allOut: cover property (chanOe == 8'hFF);
endmodule

bind dpt_port_top dpt_port_top_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .chanIn(chanIn),
    .chanOut(chanOut), .chanOe(chanOe), .rxValid(rxValid),
    .rxBreak(rxBreak), .cmdMode(cmdMode), .netPort(netPort));

// ---- dpt_pin_model.sv ----
// Switches and lamps on the channel pins
`timescale 1ns/1ps
module dpt_pin_model
    import dpt_pkg::*;
(
    input  wire logic [CHAN_COUNT-1:0] chanOut,
    input  wire logic [CHAN_COUNT-1:0] chanOe,
    input  wire logic [CHAN_COUNT-1:0] sw,
    output logic [CHAN_COUNT-1:0]      chanIn
);
    // Driven pins show the block level, released pins the switch level
    assign chanIn = (chanOe & chanOut) | (~chanOe & sw);
endmodule

// ---- dpt_port_top_test.sv ----
// Self-checking bench for the digital channel block
`timescale 1ns/1ps
module dpt_port_top_test import dpt_pkg::*;;
    logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        rxValid = 0, rxBreak = 0, pready, pslverr, cmdMode, err;
    logic [7:0]  paddr = 0, rxData = 0, sw = 8'h24;
    logic [7:0]  chanIn, chanOut, chanOe;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [4:0]  strengthLevel = 0;
    logic [13:0] netPort;
    int          fails = 0, checks = 0;

    always #2.5 clk = ~clk;

    dpt_port_top #(.TRIG_GAP_LIMIT(32'd20)) uut (.clk(clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .chanIn(chanIn),
        .chanOut(chanOut), .chanOe(chanOe),
        .strengthLevel(strengthLevel), .rxValid(rxValid),
        .rxData(rxData), .rxBreak(rxBreak), .cmdMode(cmdMode),
        .netPort(netPort));
    dpt_pin_model pins (.chanOut(chanOut), .chanOe(chanOe), .sw(sw),
        .chanIn(chanIn));

    task conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            conclude;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task send(input logic [7:0] c, input int k);
        repeat (k) begin
            rxValid <= 1'b1;
            rxData <= c;
            @(posedge clk);
        end
        rxValid <= 1'b0;
        @(posedge clk);
    endtask
    task waitMode(input logic e);
        int n;
        n = 0;
        while (cmdMode !== e && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk(cmdMode, e);
        if (cmdMode !== e)
            conclude;
    endtask

    task t_reset;
        cyc(2);
        chk(chanOe, 8'h3E);
        chk(netPort, 14'd5001);
        rdc(OFS_CHAN_DIR, 32'h0);
        rdc(OFS_CHAN_LEVEL, 32'h0);
        rdc(OFS_CMD_CFG, 32'h002B_0102);
        rdc(OFS_TRIG_GAP, 32'd20);
    endtask
    task t_chan;
        wr(OFS_CMD_CFG, 32'h002B_0002);
        wr(OFS_CHAN_DIR, 32'h81);
        wr(OFS_CHAN_LEVEL, 32'hFF);
        chk(chanOe, 8'h81);
        chk(chanOut, 8'h81);
        rdc(OFS_STATUS, 32'hA5);
    endtask
    task t_global;
        wr(OFS_GLOBAL, 32'h3);
        chk(chanOe, 8'hFF);
        chk(chanOut, 8'hFF);
        rdc(OFS_CHAN_DIR, 32'hFF);
        rdc(OFS_CHAN_LEVEL, 32'hFF);
        rdc(OFS_GLOBAL, 32'h3);
        wr(OFS_GLOBAL, 32'h1);
        chk(chanOut, 8'h00);
        wr(OFS_GLOBAL, 32'h0);
        chk(chanOe, 8'h00);
    endtask
    task t_led;
        strengthLevel <= 5'b10110;
        wr(OFS_CHAN_LEVEL, 32'h80);
        wr(OFS_CHAN_DIR, 32'h80);
        wr(OFS_CMD_CFG, 32'h002B_0100);
        chk(chanOe, 8'hBE);
        chk(chanOut, 8'hAC);
        wr(OFS_CHAN_DIR, 32'h0);
        wr(OFS_CMD_CFG, 32'h002B_0000);
    endtask
    task t_disabled;
        send(8'h2B, 3);
        rxBreak <= 1'b1;
        sw <= 8'hA4;
        @(posedge clk);
        rxBreak <= 1'b0;
        cyc(6);
        chk(cmdMode, 1'b0);
        sw <= 8'h24;
    endtask
    task t_pin;
        wr(OFS_CMD_CFG, 32'h002B_0001);
        sw <= 8'hA4;
        cyc(2);
        chk(cmdMode, 1'b0);
        waitMode(1'b1);
        sw <= 8'h24;
        waitMode(1'b0);
    endtask
    task t_chars;
        wr(OFS_CMD_CFG, 32'h002B_0002);
        send(8'h2B, 3);
        waitMode(1'b1);
        rdc(OFS_STATUS, 32'h124);
        wr(OFS_CMD_CTRL, 32'h1);
        waitMode(1'b0);
        send(8'h2B, 2);
        send(8'h41, 1);
        send(8'h2B, 1);
        cyc(4);
        chk(cmdMode, 1'b0);
        cyc(30);
        send(8'h2B, 2);
        cyc(30);
        send(8'h2B, 1);
        cyc(4);
        chk(cmdMode, 1'b0);
    endtask
    task t_break;
        wr(OFS_CMD_CFG, 32'h002B_0003);
        rxBreak <= 1'b1;
        @(posedge clk);
        rxBreak <= 1'b0;
        waitMode(1'b1);
        wr(OFS_CMD_CTRL, 32'h1);
        waitMode(1'b0);
    endtask
    task t_net;
        wr(OFS_NET_PORT, 32'd9999);
        chk(netPort, 14'd9999);
        wr(OFS_NET_PORT, 32'd10000);
        chk(netPort, 14'd9999);
        wr(OFS_NET_PORT, 32'd0);
        chk(netPort, 14'd0);
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
    endtask

    initial begin
        cyc(6);
        sys_rst <= 1'b0;
        t_reset;
        t_chan;
        t_global;
        t_led;
        t_disabled;
        t_pin;
        t_chars;
        t_break;
        t_net;
        conclude;
    end
endmodule
